// *** verilog/bpic_defs.vh ***
/*
  constants for the bus peripheral interrupt chain: register indices,
  field positions, status codes, reset values.
  assumes it is included by bare name from the top design file and the tests.
*/
// Functional notes
// R1: i/o transactions last one clock longer
// R2: byte i/o data on low byte lines
// R3: i/o address selects peripheral and register
// R4: null kinds: internal operation, memory refresh
// R5: master issues internal nulls during long work
// R6: master puts refresh row on address
// R7: data strobe high throughout means null
// R8: each source has pending, enable, under-service
// R9: source maps to one vector, vector has status flag
// R10: device has master enable, chain disable, no-vector
// R11: request only when enabled, unblocked, no acknowledge
// R12: pending source passes chain outside acknowledge
// R13: during acknowledge pending or serviced source blocks chain
// R14: acknowledged source sets its under-service flag
// R15: no_vector selects drive vector or float
// R16: status flag embeds source index in vector
// R17: under-service source holds chain out low
// R18: cpu clears under-service and pending by writes
// R19: sources are linked in series in chain
// R20: acknowledge status captured at address strobe rise
// R21: master enable off acts as enables off
// R22: lower chain disable forces chain out low
// R23: reset clears all flags and master enable
// R24: strobes sampled in clock domain, chain prompt; chain input here also passes the three-stage sync filter
`ifndef BPIC_DEFS_VH
`define BPIC_DEFS_VH

`define BPIC_IDX_CTRL    4'h0
`define BPIC_IDX_PEND    4'h1
`define BPIC_IDX_ENAB    4'h2
`define BPIC_IDX_IUS     4'h3
`define BPIC_IDX_VEC0    4'h4
`define BPIC_IDX_VEC1    4'h5
`define BPIC_IDX_VMAP    4'h6
`define BPIC_IDX_VIS     4'h7
`define BPIC_IDX_POLL    4'h8

`define BPIC_CTRL_ME     0
`define BPIC_CTRL_LCD    1
`define BPIC_CTRL_NV     2

`define BPIC_ST_NULL_INT 4'h0
`define BPIC_ST_NULL_REF 4'h1
`define BPIC_ST_IO       4'h2

`define BPIC_ADR_SEL_HI  15
`define BPIC_ADR_SEL_LO  8
`define BPIC_ADR_IDX_HI  3
`define BPIC_ADR_IDX_LO  0
`define BPIC_HADR_IDX_HI 5
`define BPIC_HADR_IDX_LO 2
`define BPIC_HADR_TOP    31
`define BPIC_HADR_HI0    6
`define BPIC_HTRANS_ACT  1

`define BPIC_SYNC_W      26
`define BPIC_SYNC_RST    26'h3c00000
`define BPIC_SB_AS       25
`define BPIC_SB_DS       24
`define BPIC_SB_CEI      23
`define BPIC_SB_ACK      22
`define BPIC_SB_RW       21
`define BPIC_SB_BW       20
`define BPIC_SB_ST_HI    19
`define BPIC_SB_ST_LO    16

`define BPIC_RST_BYTE    8'h00
`define BPIC_ZERO_HI     8'h00
`define BPIC_STAT_W      2

`endif

// *** verilog/bpic_sync.v ***
/*
  three-stage input synchroniser with agreement filter.
  assumes asynchronous pin inputs and a constant idle value at reset.
*/
`timescale 1ns/1ps
module bpic_sync #(
  parameter         W   = 1,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  input  wire         clk,
  input  wire         nrst,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  integer     i;

  // s1 feeds s2 only; a bit moves once stages two and three agree
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= RST;
      s2_r <= RST;
      s3_r <= RST;
      q    <= RST;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (i = 0; i < W; i = i + 1) begin
        if (s2_r[i] == s3_r[i]) begin
          q[i] <= s3_r[i];
        end
      end
    end
  end
endmodule

// *** verilog/bpic_source.v ***
/*
  one interrupt source as a link of the priority chain.
  assumes enable already gated by master enable and same-clock inputs.
*/
`timescale 1ns/1ps
module bpic_source (
  input  wire pend,
  input  wire enab,
  input  wire under_service_flag,
  input  wire cei,
  input  wire ack_win,
  input  wire ack_cap_n,
  output reg  ceo,
  output wire req,
  output wire sel
);
  // request needs an open chain and no acknowledge latched at strobe
  assign req = pend & enab & ~under_service_flag & cei & ack_cap_n; // see R11
  assign sel = cei & pend & enab & ~under_service_flag; // see R14

  always @* begin
    if (under_service_flag) begin
      ceo = 1'b0; // see R17
    end else if (ack_win && pend && enab) begin
      ceo = 1'b0; // see R13
    end else begin
      ceo = cei; // see R12
    end
  end
endmodule

// *** verilog/bpic_top.v ***
/*
  peripheral side of a multiplexed address/data bus with a vectored
  interrupt daisy chain, registers also reachable over ahb-lite.
  assumes all bus pins are asynchronous to clk; single-word ahb access.
*/
// Local design decisions: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`include "bpic_defs.vh"
module bpic_top #(
  parameter       N       = 4,
  parameter [7:0] DEV_SEL = 8'h5a
) (
  input  wire          clk,
  input  wire          nrst,
  input  wire          hsel,
  input  wire [31:0]   haddr,
  input  wire [1:0]    htrans,
  input  wire          hwrite,
  input  wire [2:0]    hsize,
  input  wire [31:0]   hwdata,
  input  wire          hready,
  output reg  [31:0]   hrdata,
  output wire          hreadyout,
  output wire          hresp,
  input  wire          as_n,
  input  wire          ds_n,
  input  wire          rw,
  input  wire          bw,
  input  wire [3:0]    status,
  input  wire          acknowledge_cycle_n,
  input  wire [15:0]   ad_i,
  output reg  [15:0]   ad_o,
  output reg           ad_oe_n,
  input  wire          chain_enable_in,
  output wire          chain_enable_out,
  output wire          irq_request_n,
  input  wire [N-1:0]  src_event
);
  // DEV_SEL default is arbitrary; the index field limits N to four

  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_ADDR = 2'd1;
  localparam [1:0] ST_DATA = 2'd2;

  wire [`BPIC_SYNC_W-1:0] pin_s;
  wire                    as_s;
  wire                    ds_s;
  wire                    cei_s;
  wire                    ack_s;
  wire [15:0]             ad_s;
  reg                     as_q_r;
  reg                     ds_q_r;
  wire                    as_rise;
  wire                    as_fall;
  wire                    ds_rise;
  wire                    ds_fall;

  reg  [1:0]              st_r;
  reg                     ack_cap_n_r;
  reg                     rw_cap_r;
  reg                     bw_cap_r;
  reg  [3:0]              stat_cap_r;
  reg  [15:0]             adr_cap_r;

  reg                     me_r;
  reg                     lcd_r;
  reg                     nv_r;
  reg  [N-1:0]            pend_r;
  reg  [N-1:0]            enab_r;
  reg  [N-1:0]            ius_r;
  reg  [7:0]              vec0_r;
  reg  [7:0]              vec1_r;
  reg  [N-1:0]            vmap_r;
  reg  [1:0]              vis_r;

  reg                     hact_r;
  reg                     hwr_r;
  reg  [3:0]              hidx_r;
  reg                     hmap_r;
  reg                     mwr_r;
  reg  [3:0]              midx_r;
  reg  [7:0]              mdat_r;

  wire                    ahb_wr;
  wire                    wr_en;
  wire [3:0]              wr_idx;
  wire [7:0]              wr_dat;
  wire [N:0]              chain;
  wire [N-1:0]            req;
  wire [N-1:0]            sel;
  wire [N-1:0]            enab_g;
  wire                    ack_win;
  wire                    io_hit;
  wire                    do_ack;
  wire [N-1:0]            ack_set;
  reg  [`BPIC_STAT_W-1:0] sel_idx;
  reg                     sel_any;
  reg  [`BPIC_STAT_W-1:0] poll_idx;
  reg                     poll_any;
  reg  [7:0]              vec_out;
  integer                 k;

  bpic_sync #(
    .W   (`BPIC_SYNC_W),
    .RST (`BPIC_SYNC_RST)
  ) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .d    ({as_n, ds_n, chain_enable_in, acknowledge_cycle_n, rw, bw, status, ad_i}),
    .q    (pin_s)
  );

  // strobes and chain input only reach logic after the filter
  assign as_s  = pin_s[`BPIC_SB_AS];  // see R24
  assign ds_s  = pin_s[`BPIC_SB_DS];
  assign cei_s = pin_s[`BPIC_SB_CEI];
  assign ack_s = pin_s[`BPIC_SB_ACK];
  assign ad_s  = pin_s[15:0];

  assign as_rise = as_s & ~as_q_r;
  assign as_fall = ~as_s & as_q_r;
  assign ds_rise = ds_s & ~ds_q_r;
  assign ds_fall = ~ds_s & ds_q_r;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      as_q_r <= 1'b1;
      ds_q_r <= 1'b1;
    end else begin
      as_q_r <= as_s;
      ds_q_r <= ds_s;
    end
  end

  // register read shared by both buses
  function [7:0] bpic_rd;
    input [3:0] idx;
    begin
      case (idx)
        `BPIC_IDX_CTRL: bpic_rd = {5'h00, nv_r, lcd_r, me_r};
        `BPIC_IDX_PEND: bpic_rd = {{(8-N){1'b0}}, pend_r};
        `BPIC_IDX_ENAB: bpic_rd = {{(8-N){1'b0}}, enab_r};
        `BPIC_IDX_IUS:  bpic_rd = {{(8-N){1'b0}}, ius_r};
        `BPIC_IDX_VEC0: bpic_rd = vec0_r;
        `BPIC_IDX_VEC1: bpic_rd = vec1_r;
        `BPIC_IDX_VMAP: bpic_rd = {{(8-N){1'b0}}, vmap_r};
        `BPIC_IDX_VIS:  bpic_rd = {6'h00, vis_r};
        `BPIC_IDX_POLL: bpic_rd = {poll_any, 5'h00, poll_idx};
        default:        bpic_rd = `BPIC_RST_BYTE;
      endcase
    end
  endfunction

  // master enable off gates every source enable
  assign enab_g = enab_r & {N{me_r}}; // see R21

  // acknowledge window: strobe rise up to data strobe fall
  assign ack_win = ~ack_cap_n_r & (st_r == ST_ADDR); // see R13

  assign chain[0] = cei_s;

  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_src
      // each source is one link; source 0 has highest priority
      bpic_source u_src (
        .pend      (pend_r[g]),
        .enab      (enab_g[g]),
        .under_service_flag       (ius_r[g]),
        .cei       (chain[g]), // see R19
        .ack_win   (ack_win),
        .ack_cap_n (ack_cap_n_r),
        .ceo       (chain[g+1]),
        .req       (req[g]),
        .sel       (sel[g])
      );
    end
  endgenerate

  assign chain_enable_out = chain[N] & ~lcd_r; // see R22
  assign irq_request_n    = ~(|req); // see R11

  // lowest-numbered source wins both the acknowledge and the poll
  always @* begin
    sel_any  = 1'b0;
    sel_idx  = {`BPIC_STAT_W{1'b0}};
    poll_any = 1'b0;
    poll_idx = {`BPIC_STAT_W{1'b0}};
    for (k = N - 1; k >= 0; k = k - 1) begin
      if (sel[k]) begin
        sel_any = 1'b1;
        sel_idx = k[`BPIC_STAT_W-1:0];
      end
      if (pend_r[k]) begin
        poll_any = 1'b1;
        poll_idx = k[`BPIC_STAT_W-1:0];
      end
    end
  end

  // vector per source through the map; status replaces the low bits
  always @* begin
    if (vmap_r[sel_idx]) begin
      vec_out = vec1_r; // see R9
      if (vis_r[1]) begin
        vec_out = {vec1_r[7:`BPIC_STAT_W], sel_idx}; // see R16
      end
    end else begin
      vec_out = vec0_r;
      if (vis_r[0]) begin
        vec_out = {vec0_r[7:`BPIC_STAT_W], sel_idx}; // see R16
      end
    end
  end

  assign do_ack  = ds_fall & (st_r == ST_ADDR) & ~ack_cap_n_r;
  assign ack_set = (do_ack && sel_any) ? sel : {N{1'b0}}; // see R14

  // only i/o status addressed to this device; nulls never match
  assign io_hit = (stat_cap_r == `BPIC_ST_IO) &&
                  (adr_cap_r[`BPIC_ADR_SEL_HI:`BPIC_ADR_SEL_LO] == DEV_SEL); // see R3 R4

  // mux-bus transaction sequencer
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r        <= ST_IDLE;
      ack_cap_n_r <= 1'b1;
      rw_cap_r    <= 1'b1;
      bw_cap_r    <= 1'b0;
      stat_cap_r  <= `BPIC_ST_NULL_INT;
      adr_cap_r   <= 16'h0000;
      ad_o        <= 16'h0000;
      ad_oe_n     <= 1'b1;
    end else begin
      if (as_rise) begin
        ack_cap_n_r <= ack_s; // see R20
        rw_cap_r    <= pin_s[`BPIC_SB_RW];
        bw_cap_r    <= pin_s[`BPIC_SB_BW];
        stat_cap_r  <= pin_s[`BPIC_SB_ST_HI:`BPIC_SB_ST_LO];
        adr_cap_r   <= ad_s;
        ad_oe_n     <= 1'b1;
        st_r        <= ST_ADDR;
      end else begin
        case (st_r)
          ST_IDLE: begin
            st_r <= ST_IDLE;
          end
          ST_ADDR: begin
            // a data strobe that never falls leaves nothing done
            if (as_fall) begin
              st_r <= ST_IDLE; // see R7
            end else if (ds_fall) begin
              st_r <= ST_DATA;
              if (!ack_cap_n_r) begin
                // floating lines let outside logic supply the vector
                ad_o    <= {`BPIC_ZERO_HI, vec_out};
                ad_oe_n <= nv_r | ~sel_any; // see R15
              end else if (io_hit && rw_cap_r) begin
                // byte or word, data sits on the low byte lines
                ad_o    <= {`BPIC_ZERO_HI,
                            bpic_rd(adr_cap_r[`BPIC_ADR_IDX_HI:`BPIC_ADR_IDX_LO])}; // see R2
                ad_oe_n <= 1'b0;
              end
            end
          end
          ST_DATA: begin
            if (ds_rise || as_fall) begin
              ad_oe_n <= 1'b1;
              st_r    <= ST_IDLE;
            end
          end
          default: begin
            st_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // i/o write: byte taken from the low lines when the strobe falls;
  // the filter delay is covered by the extra i/o clock, see R1
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mwr_r  <= 1'b0;
      midx_r <= 4'h0;
      mdat_r <= `BPIC_RST_BYTE;
    end else begin
      if (ds_fall && st_r == ST_ADDR && ack_cap_n_r && io_hit && !rw_cap_r) begin
        mwr_r  <= 1'b1;
        midx_r <= adr_cap_r[`BPIC_ADR_IDX_HI:`BPIC_ADR_IDX_LO];
        mdat_r <= ad_s[7:0]; // see R2
      end else if (!ahb_wr) begin
        mwr_r  <= 1'b0;
      end
    end
  end

  // ahb-lite slave: zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hact_r <= 1'b0;
      hwr_r  <= 1'b0;
      hidx_r <= 4'h0;
      hmap_r <= 1'b0;
      hrdata <= 32'h00000000;
    end else begin
      if (hready) begin
        hact_r <= hsel & htrans[`BPIC_HTRANS_ACT];
        hwr_r  <= hwrite;
        hidx_r <= haddr[`BPIC_HADR_IDX_HI:`BPIC_HADR_IDX_LO];
        hmap_r <= ~(|haddr[`BPIC_HADR_TOP:`BPIC_HADR_HI0]);
        if (hsel && htrans[`BPIC_HTRANS_ACT] && !hwrite &&
            !(|haddr[`BPIC_HADR_TOP:`BPIC_HADR_HI0])) begin
          hrdata <= {24'h000000, bpic_rd(haddr[`BPIC_HADR_IDX_HI:`BPIC_HADR_IDX_LO])};
        end else begin
          hrdata <= 32'h00000000;
        end
      end
    end
  end

  // ahb writes go first; a held i/o write follows a cycle later
  assign ahb_wr = hact_r & hwr_r & hmap_r;
  assign wr_en  = ahb_wr | mwr_r;
  assign wr_idx = ahb_wr ? hidx_r : midx_r;
  assign wr_dat = ahb_wr ? hwdata[7:0] : mdat_r;

  // control and per-source flags
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      me_r   <= 1'b0; // see R23
      lcd_r  <= 1'b0;
      nv_r   <= 1'b0;
      pend_r <= {N{1'b0}};
      enab_r <= {N{1'b0}};
      ius_r  <= {N{1'b0}};
      vec0_r <= `BPIC_RST_BYTE;
      vec1_r <= `BPIC_RST_BYTE;
      vmap_r <= {N{1'b0}};
      vis_r  <= 2'b00;
    end else begin
      // pending and under-service clear by writing ones; sets win
      pend_r <= (pend_r & ~((wr_en && wr_idx == `BPIC_IDX_PEND) ?
                 wr_dat[N-1:0] : {N{1'b0}})) | src_event; // see R8 R18
      ius_r  <= (ius_r & ~((wr_en && wr_idx == `BPIC_IDX_IUS) ?
                 wr_dat[N-1:0] : {N{1'b0}})) | ack_set; // see R14 R18
      if (wr_en) begin
        case (wr_idx)
          `BPIC_IDX_CTRL: begin
            me_r  <= wr_dat[`BPIC_CTRL_ME]; // see R10
            lcd_r <= wr_dat[`BPIC_CTRL_LCD];
            nv_r  <= wr_dat[`BPIC_CTRL_NV];
          end
          `BPIC_IDX_ENAB: enab_r <= wr_dat[N-1:0]; // see R8
          `BPIC_IDX_VEC0: vec0_r <= wr_dat;
          `BPIC_IDX_VEC1: vec1_r <= wr_dat;
          `BPIC_IDX_VMAP: vmap_r <= wr_dat[N-1:0]; // see R9
          `BPIC_IDX_VIS:  vis_r  <= wr_dat[1:0];
          default: begin
            vis_r <= vis_r;
          end
        endcase
      end
    end
  end
endmodule

// *** test/bpic_top_assertions.sv ***
/* port checker for bpic_top.
   assumes strobe phases of at least 6 clocks from the bus master. */
`timescale 1ns/1ps
module bpic_top_checker (
  input wire        clk,
  input wire        nrst,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        as_n,
  input wire        ds_n,
  input wire        acknowledge_cycle_n,
  input wire [15:0] ad_o,
  input wire        ad_oe_n,
  input wire        chain_enable_in,
  input wire        chain_enable_out,
  input wire        irq_request_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_irq_blocked: assert property (
    !chain_enable_in [*6] |=> irq_request_n) else $error("irq with chain input low");
  chk_ack_no_irq: assert property (
    $rose(as_n) && !acknowledge_cycle_n |-> ##6 irq_request_n) else $error("irq in ack");
  chk_chain_follow: assert property (
    !chain_enable_in [*6] |=> !chain_enable_out) else $error("chain out high, in low");
  chk_ack_chain: assert property (
    $fell(ad_oe_n) && !acknowledge_cycle_n |-> !chain_enable_out)
    else $error("chain open at vector");
  chk_drive_ds: assert property (
    $fell(ad_oe_n) |-> !ds_n && !$past(ds_n, 3)) else $error("bus driven without strobe");
  chk_null_quiet: assert property (
    ds_n [*8] |-> ad_oe_n) else $error("bus driven, strobe high");
  chk_upper_zero: assert property (
    !ad_oe_n |-> ad_o[15:8] == 8'h00) else $error("upper byte driven");
  chk_unmapped_read: assert property (
    hsel && htrans[1] && hready && !hwrite && haddr[31:6] != 0 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  chk_reset_idle: assert property (
    $rose(nrst) |-> irq_request_n && ad_oe_n) else $error("not idle after reset");
  cover property ($fell(irq_request_n));
  cover property ($fell(ad_oe_n) && !acknowledge_cycle_n);
  cover property ($rose(chain_enable_out));
endmodule
bind bpic_top bpic_top_checker u_chk (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hrdata, .as_n, .ds_n, .acknowledge_cycle_n, .ad_o, .ad_oe_n,
  .chain_enable_in, .chain_enable_out, .irq_request_n);

// *** test/bpic_cpu.sv ***
/* bus master model: strobes, status, acknowledge and the mux bus.
   assumes the peripheral filters strobes, so each phase lasts 6+ clocks. */
`timescale 1ns/1ps
`include "bpic_defs.vh"
module bpic_cpu (
  input  wire        clk,
  input  wire [15:0] ad_o,
  input  wire        ad_oe_n,
  output reg         as_n,
  output reg         ds_n,
  output reg         rw,
  output reg         bw,
  output reg  [3:0]  status,
  output reg         acknowledge_cycle_n,
  output wire [15:0] ad_i
);
  reg [15:0] drv_r;
  reg        drv_on_r;
  // released bus shows the inverse of the last value, never a stale copy
  assign ad_i = !ad_oe_n ? ad_o : (drv_on_r ? drv_r : ~drv_r);
  initial begin
    as_n = 1'b1;
    ds_n = 1'b1;
    rw = 1'b1;
    bw = 1'b1;
    status = 4'h0;
    acknowledge_cycle_n = 1'b1;
    drv_r = 16'h0000;
    drv_on_r = 1'b0;
  end
  // k is the acknowledge level, d uses the data strobe; call after a rising edge
  task xact(input k, input [3:0] st, input r, input [15:0] a, input [15:0] w,
            input d, output [15:0] rd);
    begin
      as_n <= 1'b0;
      acknowledge_cycle_n <= k;
      status <= st;
      rw <= r;
      drv_r <= a;
      drv_on_r <= 1'b1;
      repeat (6) @(posedge clk);
      as_n <= 1'b1; // address and status valid at this rise
      repeat (6) @(posedge clk);
      drv_r <= w;
      drv_on_r <= !r;
      @(posedge clk);
      ds_n <= !d; // strobe kept high makes the cycle null
      repeat (8) @(posedge clk);
      if (st == `BPIC_ST_IO) @(posedge clk);
      rd = ad_i;
      ds_n <= 1'b1;
      repeat (8) @(posedge clk);
      drv_on_r <= 1'b0;
      acknowledge_cycle_n <= 1'b1;
      // a following call must not reassign these in the same step
      @(posedge clk);
    end
  endtask
endmodule

// *** test/bus_peripheral_interrupt_chain_tb_top.sv ***
/* self-checking bench for bpic_top: ahb registers, strobe-side master
   model, random vectors and events. assumes zero-wait ahb answers. */
`timescale 1ns/1ps
`include "bpic_defs.vh"
module bus_peripheral_interrupt_chain_tb_top;
  localparam [7:0] SEL = 8'h5a;
  reg         clk, nrst, hsel, hwrite, chain_enable_in, vector_carries_status, m;
  reg  [31:0] haddr, hwdata, seed, rd;
  reg  [1:0]  htrans;
  reg  [3:0]  src_event;
  reg  [15:0] md;
  reg  [7:0]  v;
  wire [31:0] hrdata;
  wire        hreadyout, as_n, ds_n, rw, bw, ack_n, ad_oe_n, chain_enable_out, irq_request_n;
  wire [3:0]  status;
  wire [15:0] ad_i, ad_o;
  integer     err_total, compares, i, drv_cnt;

  bpic_top #(.N(4), .DEV_SEL(SEL)) u_dut (.clk(clk), .nrst(nrst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .as_n(as_n),
    .ds_n(ds_n), .rw(rw), .bw(bw), .status(status), .acknowledge_cycle_n(ack_n),
    .ad_i(ad_i), .ad_o(ad_o), .ad_oe_n(ad_oe_n), .chain_enable_in(chain_enable_in),
    .chain_enable_out(chain_enable_out), .irq_request_n(irq_request_n),
    .src_event(src_event));
  bpic_cpu u_cpu (.clk(clk), .ad_o(ad_o), .ad_oe_n(ad_oe_n), .as_n(as_n), .ds_n(ds_n),
    .rw(rw), .bw(bw), .status(status), .acknowledge_cycle_n(ack_n), .ad_i(ad_i));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // counts cycles in which the device drives the mux bus
  always @(posedge clk or negedge nrst) begin
    if (!nrst) drv_cnt <= 0;
    else if (!ad_oe_n) drv_cnt <= drv_cnt + 1;
  end

  task stop_test;
    begin
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task check(input string nm, input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  function [31:0] rnd();
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd = seed;
    end
  endfunction
  function [7:0] vec_exp(input [7:0] vv, input s, input [1:0] k);
    vec_exp = s ? {vv[7:2], k} : vv;
  endfunction
  // one single-word transfer; called just after a rising edge
  task ahb(input w, input [31:0] a, input [31:0] wd);
    begin
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
    end
  endtask
  task wr(input [3:0] k, input [7:0] d);
    ahb(1'b1, {26'd0, k, 2'b00}, {24'd0, d});
  endtask
  task rdc(input string nm, input [3:0] k, input [7:0] e);
    begin
      ahb(1'b0, {26'd0, k, 2'b00}, 32'd0);
      check(nm, rd, {24'd0, e});
    end
  endtask
  task ev(input [3:0] s);
    begin
      src_event <= s;
      @(posedge clk);
      src_event <= 4'h0;
      @(posedge clk);
    end
  endtask
  task ack;
    u_cpu.xact(1'b0, 4'h7, 1'b1, seed[31:16], 16'h0000, 1'b1, md);
  endtask
  // clears go over the strobe bus, so the next address strobe also
  // drops the acknowledge latched by the last ack
  task clr(input [7:0] k);
    begin
      u_cpu.xact(1'b1, `BPIC_ST_IO, 1'b0, {SEL, 4'h0, `BPIC_IDX_PEND}, {8'h00, k}, 1'b1, md);
      u_cpu.xact(1'b1, `BPIC_ST_IO, 1'b0, {SEL, 4'h0, `BPIC_IDX_IUS}, {8'h00, k}, 1'b1, md);
    end
  endtask
  task pins(input integer n, input e_irq, input e_ceo);
    begin
      repeat (n) @(posedge clk);
      @(negedge clk);
      check("irq_request_n", irq_request_n, e_irq);
      check("chain_enable_out", chain_enable_out, e_ceo);
      @(posedge clk);
    end
  endtask

  initial begin
    #200000;
    err_total = err_total + 1;
    stop_test;
  end

  initial begin
    seed = 32'hc36d;
    err_total = 0;
    compares = 0;
    nrst = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} = 0;
    chain_enable_in = 1'b1;
    src_event = 4'h0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    pins(6, 1'b1, 1'b1);
    for (i = 0; i < 8; i = i + 1) rdc("reset value", i[3:0], 8'h00);
    ahb(1'b0, 32'h0000_0040, 32'd0);
    check("unmapped", rd, 32'd0);
    wr(2, 8'h0f);
    for (i = 0; i < 4; i = i + 1) begin
      seed = rnd();
      v = seed[7:0];
      vector_carries_status = seed[8];
      m = seed[9];
      wr(4'h4 + m, v);
      wr(7, {6'd0, vector_carries_status, vector_carries_status});
      wr(6, m ? (8'h01 << i) : 8'h00);
      wr(0, 8'h00);
      ev(4'h1 << i);
      rdc("pending", 1, 8'h01 << i);
      pins(1, 1'b1, 1'b1);
      wr(0, 8'h01);
      pins(1, 1'b0, 1'b1);
      ack;
      check("vector", md, {8'h00, vec_exp(v, vector_carries_status, i[1:0])});
      rdc("under service", 3, 8'h01 << i);
      pins(1, 1'b1, 1'b0);
      clr(8'h01 << i);
      pins(1, 1'b1, 1'b1);
    end
    wr(4, v);
    wr(6, 8'h00);
    wr(7, 8'h03);
    ev(4'b1010);
    ack;
    check("first vector", md, {8'h00, v[7:2], 2'd1});
    pins(1, 1'b1, 1'b0);
    clr(8'h02);
    pins(1, 1'b0, 1'b1);
    ack;
    check("second vector", md, {8'h00, v[7:2], 2'd3});
    clr(8'h08);
    ev(4'h4);
    chain_enable_in <= 1'b0;
    pins(6, 1'b1, 1'b0);
    chain_enable_in <= 1'b1;
    pins(6, 1'b0, 1'b1);
    wr(0, 8'h03);
    pins(1, 1'b0, 1'b0);
    wr(0, 8'h05);
    i = drv_cnt;
    ack;
    check("no vector drive", drv_cnt, i);
    rdc("nv service", 3, 8'h04);
    wr(1, 8'h04);
    wr(3, 8'h04);
    u_cpu.xact(1'b1, `BPIC_ST_IO, 1'b0, {SEL, 8'h02}, {seed[7:0], 8'h05}, 1'b1, md);
    rdc("io write", 2, 8'h05);
    u_cpu.xact(1'b1, `BPIC_ST_IO, 1'b1, {SEL, 8'h02}, 16'h0000, 1'b1, md);
    check("io read", md, 16'h0005);
    u_cpu.xact(1'b1, `BPIC_ST_IO, 1'b0, {~SEL, 8'h02}, 16'h000a, 1'b1, md);
    u_cpu.xact(1'b1, `BPIC_ST_IO, 1'b0, {SEL, 8'h02}, 16'h000a, 1'b0, md);
    u_cpu.xact(1'b1, `BPIC_ST_NULL_INT, 1'b1, seed[15:0], 16'h000a, 1'b0, md);
    u_cpu.xact(1'b1, `BPIC_ST_NULL_REF, 1'b1, {8'h00, v}, 16'h000a, 1'b0, md);
    rdc("ignored writes", 2, 8'h05);
    stop_test;
  end
endmodule
